// file: design/jpi_params.svh
`ifndef JPI_PARAMS_SVH
`define JPI_PARAMS_SVH

// ----------------------------------------
// instruction opcodes
// ----------------------------------------
`define JPI_OP_CORE_RESET 4'hc
`define JPI_OP_UNLOCK 4'h4
`define JPI_OP_CMD 4'h5
`define JPI_OP_PAGE_FILL 4'h6
`define JPI_OP_PAGE_DUMP 4'h7
`define JPI_OP_BYPASS 4'hf
`define JPI_IR_CAPTURE 4'h1

// ----------------------------------------
// signature and reset values
// ----------------------------------------
`define JPI_UNLOCK_SIG 16'ha370
`define JPI_CTRL_RESET 32'h0000_0001
`define JPI_CTRL_EN_BIT 0

// ----------------------------------------
// apb offsets
// ----------------------------------------
`define JPI_OFS_CTRL 8'h00
`define JPI_OFS_STATUS 8'h04
`define JPI_OFS_CMD_RESULT 8'h08
`define JPI_OFS_CMD_WORD 8'h0c
`define JPI_OFS_PBUF_ADDR 8'h10
`define JPI_OFS_PBUF_DATA 8'h14

`endif

// file: design/jpi_pkg.sv
package jpi_pkg;

    // gray code along the usual scan path
    typedef enum logic [3:0] {
        JPI_TLR = 4'h0,
        JPI_RTI = 4'h1,
        JPI_SELDR = 4'h3,
        JPI_CAPDR = 4'h2,
        JPI_SHDR = 4'h6,
        JPI_EX1DR = 4'h7,
        JPI_PADR = 4'h5,
        JPI_EX2DR = 4'h4,
        JPI_UPDR = 4'hc,
        JPI_SELIR = 4'hd,
        JPI_CAPIR = 4'hf,
        JPI_SHIR = 4'he,
        JPI_EX1IR = 4'ha,
        JPI_PAIR = 4'hb,
        JPI_EX2IR = 4'h9,
        JPI_UPIR = 4'h8
    } jpi_tap_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jpi_pins_s;

    typedef struct packed {
        logic cmd_armed;
        logic prog_mode;
        logic core_reset;
        logic [3:0] ir;
        logic [3:0] tap;
    } jpi_status_s;

endpackage

// file: design/jpi_page_mem.sv
`timescale 1ns/1ps
`include "jpi_params.svh"

module jpi_page_mem (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [6:0] waddr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [6:0] raddr_in,
    output logic [7:0] rdata_out
);

    logic [7:0] mem [0:127];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_out <= mem[raddr_in];
    end

endmodule

// file: design/jpi_top.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "jpi_params.svh"

module jpi_top import jpi_pkg::*; (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic core_reset_out,
    output logic prog_mode_out,
    output logic [14:0] cmd_word_out,
    output logic cmd_strobe_out,
    output logic exec_clk_out,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);

    // ----------------------------------------
    // pin synchronisers and tck edges
    // ----------------------------------------
    jpi_pins_s pin_s1;
    jpi_pins_s pin_s2;
    logic tck_d;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            tck_d <= 1'b0;
        end else begin
            pin_s1 <= '{tck: tck_in, tms: tms_in, tdi: tdi_in};
            pin_s2 <= pin_s1;
            tck_d <= pin_s2.tck;
        end
    end

    wire tck_rise = pin_s2.tck & ~tck_d;
    wire tck_fall = ~pin_s2.tck & tck_d;
    wire tms = pin_s2.tms;
    wire tdi = pin_s2.tdi;
    logic jtag_en;
    logic [14:0] cmd_result;
    logic [6:0] pbuf_addr;

    // ----------------------------------------
    // tap controller
    // ----------------------------------------
    jpi_tap_e tap;
    jpi_tap_e next_tap;

    // next state depends on tms only, never on the instruction
    always_comb begin
        case (tap)
            JPI_TLR: next_tap = tms ? JPI_TLR : JPI_RTI;
            JPI_RTI: next_tap = tms ? JPI_SELDR : JPI_RTI;
            JPI_SELDR: next_tap = tms ? JPI_SELIR : JPI_CAPDR;
            JPI_CAPDR: next_tap = tms ? JPI_EX1DR : JPI_SHDR;
            JPI_SHDR: next_tap = tms ? JPI_EX1DR : JPI_SHDR;
            JPI_EX1DR: next_tap = tms ? JPI_UPDR : JPI_PADR;
            JPI_PADR: next_tap = tms ? JPI_EX2DR : JPI_PADR;
            JPI_EX2DR: next_tap = tms ? JPI_UPDR : JPI_SHDR;
            JPI_UPDR: next_tap = tms ? JPI_SELDR : JPI_RTI;
            JPI_SELIR: next_tap = tms ? JPI_TLR : JPI_CAPIR;
            JPI_CAPIR: next_tap = tms ? JPI_EX1IR : JPI_SHIR;
            JPI_SHIR: next_tap = tms ? JPI_EX1IR : JPI_SHIR;
            JPI_EX1IR: next_tap = tms ? JPI_UPIR : JPI_PAIR;
            JPI_PAIR: next_tap = tms ? JPI_EX2IR : JPI_PAIR;
            JPI_EX2IR: next_tap = tms ? JPI_UPIR : JPI_SHIR;
            JPI_UPIR: next_tap = tms ? JPI_SELDR : JPI_RTI;
            default: next_tap = JPI_TLR;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || !jtag_en) begin
            tap <= JPI_TLR;
        end else if (tck_rise) begin
            tap <= next_tap;
        end
    end

    wire act_cap = tck_rise & (tap == JPI_CAPDR);
    wire act_sh = tck_rise & (tap == JPI_SHDR);
    wire act_up = tck_rise & (tap == JPI_UPDR);

    // ----------------------------------------
    // instruction register
    // ----------------------------------------
    logic [3:0] ir;
    logic [3:0] ir_sh;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ir_sh <= '0;
        end else if (tck_rise && tap == JPI_CAPIR) begin
            ir_sh <= `JPI_IR_CAPTURE;
        end else if (tck_rise && tap == JPI_SHIR) begin
            ir_sh <= {tdi, ir_sh[3:1]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || tap == JPI_TLR) begin
            ir <= `JPI_OP_BYPASS;
        end else if (tck_rise && tap == JPI_UPIR) begin
            ir <= ir_sh;
        end
    end

    wire sel_rst = (ir == `JPI_OP_CORE_RESET);
    wire sel_unl = (ir == `JPI_OP_UNLOCK);
    wire sel_cmd = (ir == `JPI_OP_CMD);
    wire sel_fill = (ir == `JPI_OP_PAGE_FILL);
    wire sel_dump = (ir == `JPI_OP_PAGE_DUMP);
    wire sel_byp = ~(sel_rst | sel_unl | sel_cmd | sel_fill | sel_dump);

    // ----------------------------------------
    // reset chain, unlock register and programming mode
    // ----------------------------------------
    // no update stage: reset follows the shifting bit at once
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_reset_out <= 1'b0;
        end else if (act_sh && sel_rst) begin
            core_reset_out <= tdi;
        end
    end

    logic [15:0] unlock_sh;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            unlock_sh <= '0;
            prog_mode_out <= 1'b0;
        end else if (act_sh && sel_unl) begin
            unlock_sh <= {tdi, unlock_sh[15:1]};
        end else if (act_up && sel_unl) begin
            prog_mode_out <= (unlock_sh == `JPI_UNLOCK_SIG);
        end
    end

    // ----------------------------------------
    // command register and execution clock
    // ----------------------------------------
    logic [14:0] cmd_sh;
    logic cmd_armed;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_sh <= '0;
        end else if (act_cap && sel_cmd) begin
            cmd_sh <= cmd_result;
        end else if (act_sh && sel_cmd) begin
            cmd_sh <= {tdi, cmd_sh[14:1]};
        end
    end

    // armed from a command update until the next command capture or test-logic-reset
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_word_out <= '0;
            cmd_strobe_out <= 1'b0;
            cmd_armed <= 1'b0;
            exec_clk_out <= 1'b0;
        end else begin
            cmd_strobe_out <= act_up & sel_cmd;
            exec_clk_out <= tck_rise & (tap == JPI_RTI) & sel_cmd & cmd_armed;
            if (act_up && sel_cmd) begin
                cmd_word_out <= cmd_sh;
                cmd_armed <= 1'b1;
            end else if ((act_cap && sel_cmd) || tap == JPI_TLR) begin
                cmd_armed <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // page chains through one byte shifter, bypass and tdo
    // ----------------------------------------
    logic [7:0] page_sh;
    logic [2:0] bit_cnt;
    logic [6:0] pg_ptr;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [7:0] mem_wdata;

    wire page_sel = sel_fill | sel_dump;
    wire byte_done = (bit_cnt == 3'h7);
    wire [7:0] next_fill_byte = {tdi, page_sh[7:1]};

    always_ff @(posedge clk_in) begin
        if (srst_in || (act_cap && page_sel)) begin
            bit_cnt <= '0;
            pg_ptr <= '0;
        end else if (act_sh && page_sel) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                pg_ptr <= pg_ptr + 7'h1;
            end
        end
    end

    // dump starts from an empty shifter: eight filler bits
    always_ff @(posedge clk_in) begin
        if (srst_in || (act_cap && sel_dump)) begin
            page_sh <= '0;
        end else if (act_sh && sel_fill) begin
            page_sh <= next_fill_byte;
        end else if (act_sh && sel_dump) begin
            page_sh <= byte_done ? mem_rdata : {1'b0, page_sh[7:1]};
        end
    end

    wire apb_wr;
    wire a_pbuf_data;
    wire fill_wr = act_sh & sel_fill & byte_done;

    // jtag fill wins over a software write in the same cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mem_we <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
        end else begin
            mem_we <= fill_wr | (apb_wr & a_pbuf_data);
            mem_waddr <= fill_wr ? pg_ptr : pbuf_addr;
            mem_wdata <= fill_wr ? next_fill_byte : pwdata_in[7:0];
        end
    end

    wire [6:0] mem_raddr = sel_dump ? pg_ptr : pbuf_addr;

    jpi_page_mem u_mem (
        .clk_in(clk_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(mem_raddr),
        .rdata_out(mem_rdata)
    );

    logic byp;

    always_ff @(posedge clk_in) begin
        if (srst_in || (act_cap && sel_byp)) begin
            byp <= 1'b0;
        end else if (act_sh && sel_byp) begin
            byp <= tdi;
        end
    end

    wire dr_lsb = sel_rst ? core_reset_out :
                  sel_unl ? unlock_sh[0] :
                  sel_cmd ? cmd_sh[0] :
                  page_sel ? page_sh[0] : byp;

    // tdo moves on the falling tck edge so the programmer samples it stable
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_out <= (tap == JPI_SHDR) | (tap == JPI_SHIR);
            tdo_out <= (tap == JPI_SHIR) ? ir_sh[0] : dr_lsb;
        end
    end

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    wire a_ctrl = (paddr_in == `JPI_OFS_CTRL);
    wire a_status = (paddr_in == `JPI_OFS_STATUS);
    wire a_result = (paddr_in == `JPI_OFS_CMD_RESULT);
    wire a_word = (paddr_in == `JPI_OFS_CMD_WORD);
    wire a_pbuf_addr = (paddr_in == `JPI_OFS_PBUF_ADDR);
    assign a_pbuf_data = (paddr_in == `JPI_OFS_PBUF_DATA);
    wire mapped = a_ctrl | a_status | a_result | a_word | a_pbuf_addr | a_pbuf_data;
    wire acc_first = psel_in & penable_in & ~pready_out;
    assign apb_wr = psel_in & penable_in & pready_out & pwrite_in & mapped;

    jpi_status_s status;
    assign status = '{cmd_armed: cmd_armed, prog_mode: prog_mode_out,
                      core_reset: core_reset_out, ir: ir, tap: tap};

    wire [31:0] rd_mux = a_ctrl ? {31'h0, jtag_en} :
                         a_status ? {21'h0, status} :
                         a_result ? {17'h0, cmd_result} :
                         a_word ? {17'h0, cmd_word_out} :
                         a_pbuf_addr ? {25'h0, pbuf_addr} :
                         a_pbuf_data ? {24'h0, mem_rdata} : 32'h0;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= acc_first;
            pslverr_out <= acc_first & ~mapped;
            if (acc_first && !pwrite_in) begin
                prdata_out <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            jtag_en <= 1'(`JPI_CTRL_RESET);
            cmd_result <= '0;
            pbuf_addr <= '0;
        end else if (apb_wr) begin
            if (a_ctrl) begin
                jtag_en <= pwdata_in[`JPI_CTRL_EN_BIT];
            end
            if (a_result) begin
                cmd_result <= pwdata_in[14:0];
            end
            if (a_pbuf_addr) begin
                pbuf_addr <= pwdata_in[6:0];
            end
        end
    end

endmodule

// file: sim/jpi_top_asserts.sv
`timescale 1ns/1ps
module jpi_top_asserts (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic tck_in,
    input wire logic tdo_out,
    input wire logic core_reset_out,
    input wire logic prog_mode_out,
    input wire logic [14:0] cmd_word_out,
    input wire logic cmd_strobe_out,
    input wire logic exec_clk_out,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // ----------------------------------------
    // jtag side
    // ----------------------------------------
    AST_RESET_CLEARS: assert property (disable iff (1'b0)
        srst_in |=> !core_reset_out && !prog_mode_out) else $error("outputs set after reset");
    AST_CORE_RST_AT_RISE: assert property ($changed(core_reset_out) |-> tck_in)
        else $error("core reset moved away from a tck rise");
    AST_PROG_AT_RISE: assert property ($rose(prog_mode_out) |-> tck_in)
        else $error("program mode entered away from a tck rise");
    AST_TDO_AT_FALL: assert property ($changed(tdo_out) |-> !tck_in)
        else $error("tdo moved while tck high");
    AST_WORD_THEN_STROBE: assert property (!$stable(cmd_word_out) |-> ##[0:1] cmd_strobe_out)
        else $error("command word changed without strobe");
    AST_STROBE_PULSE: assert property (cmd_strobe_out |=> !cmd_strobe_out)
        else $error("strobe longer than one cycle");
    AST_EXEC_AFTER_STROBE: assert property (cmd_strobe_out |=> !exec_clk_out [*5])
        else $error("exec pulse without idle tck");
    AST_EXEC_PULSE: assert property (exec_clk_out |=> !exec_clk_out)
        else $error("exec pulse longer than one cycle");

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    AST_PREADY_LATENCY: assert property ($rose(penable_in) && psel_in |=> pready_out)
        else $error("pready late");
    AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");

    cover property (cmd_strobe_out);
    cover property (exec_clk_out);
    cover property ($rose(prog_mode_out));
    cover property (pslverr_out);
endmodule

bind jpi_top jpi_top_asserts u_chk (
    .clk_in(clk_in), .srst_in(srst_in), .tck_in(tck_in), .tdo_out(tdo_out),
    .core_reset_out(core_reset_out), .prog_mode_out(prog_mode_out),
    .cmd_word_out(cmd_word_out), .cmd_strobe_out(cmd_strobe_out),
    .exec_clk_out(exec_clk_out), .psel_in(psel_in), .penable_in(penable_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out)
);

// file: sim/jpi_prog_model.sv
`timescale 1ns/1ps
module jpi_prog_model (
    input wire logic clk_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // ----------------------------------------
    // tck cycles, 4 clk per phase
    // ----------------------------------------
    // tck stands low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // tdo taken just before the rise, one clk after the design moved it
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge clk_in);
        tdo = tdo_in;
        tck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        tck_out <= 1'b0;
    endtask

    task automatic reset_tap();
        logic t;
        repeat (5) tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask

    task automatic ir(input logic [3:0] op, output logic [3:0] cap);
        logic t;
        tick(1'b1, 1'b0, t);
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < 4; i++) begin
            tick(i == 3, op[i], cap[i]);
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
    endtask

    // sole device on the chain, so the page chains may be used
    task automatic dr(input int n, input logic [1031:0] din, output logic [1031:0] dout,
                      input int idle);
        logic t;
        dout = '0;
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        tick(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
        end
        tick(1'b1, 1'b0, t);
        tick(1'b0, 1'b0, t);
        repeat (idle) tick(1'b0, 1'b0, t);
    endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "jpi_params.svh"
module testbench;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, core_rst, prog, strobe, exec, pready, pslverr, e;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata, r;
    logic [14:0] cmd_word;
    logic [1031:0] v, o;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int execs = 0;
    int strobes = 0;
    int oe_cyc = 0;

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (exec === 1'b1) begin
            execs <= execs + 1;
        end
        if (strobe === 1'b1) begin
            strobes <= strobes + 1;
        end
        if (tdo_oe === 1'b1) begin
            oe_cyc <= oe_cyc + 1;
        end
    end

    jpi_top DUT (
        .clk_in(clk_in), .srst_in(srst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_reset_out(core_rst), .prog_mode_out(prog),
        .cmd_word_out(cmd_word), .cmd_strobe_out(strobe), .exec_clk_out(exec),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr)
    );
    jpi_prog_model prog_m (
        .clk_in(clk_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    function automatic logic [7:0] pat(input int k);
        return 8'(k * 37 + 19);
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        check("core_reset", core_rst, 1'b0);
        check("prog_mode", prog, 1'b0);
        check("tdo_oe", tdo_oe, 1'b0);
        apb(1'b0, `JPI_OFS_STATUS, 32'h0);
        check("status", r, 32'h0000_00f0);
        apb(1'b0, `JPI_OFS_CTRL, 32'h0);
        check("ctrl", r, `JPI_CTRL_RESET);
        apb(1'b1, 8'h20, 32'h1);
        check("unmapped err", e, 1'b1);
        apb(1'b1, `JPI_OFS_PBUF_ADDR, 32'hffff_ff85);
        apb(1'b0, `JPI_OFS_PBUF_ADDR, 32'h0);
        check("pbuf_addr", r, 32'h0000_0005);
    endtask

    task automatic t_instr();
        logic [3:0] c4;
        logic [3:0] ops [5] = '{`JPI_OP_CORE_RESET, `JPI_OP_UNLOCK, `JPI_OP_CMD,
                                `JPI_OP_PAGE_FILL, `JPI_OP_PAGE_DUMP};
        int ob;
        prog_m.reset_tap();
        for (int i = 0; i < 5; i++) begin
            prog_m.ir(ops[i], c4);
            check("ir capture", c4, `JPI_IR_CAPTURE);
            apb(1'b0, `JPI_OFS_STATUS, 32'h0);
            check("ir and tap", r[7:0], {ops[i], 4'h1});
        end
        prog_m.ir(`JPI_OP_BYPASS, c4);
        ob = oe_cyc;
        prog_m.dr(2, 1032'h3, o, 0);
        check("bypass", o[1:0], 2'b10);
        // driven through two shift-dr tck periods of 8 clk each
        check("tdo_oe cycles", 32'(oe_cyc - ob), 16);
    endtask

    task automatic t_core_unlock();
        logic [3:0] c4;
        prog_m.ir(`JPI_OP_CORE_RESET, c4);
        prog_m.dr(1, 1032'h1, o, 0);
        check("core reset set", core_rst, 1'b1);
        prog_m.dr(1, 1032'h0, o, 0);
        check("core reset clear", core_rst, 1'b0);
        prog_m.ir(`JPI_OP_UNLOCK, c4);
        prog_m.dr(16, 1032'(16'ha371), o, 0);
        check("bad signature", prog, 1'b0);
        // only the last 16 bits shifted stay in the register
        prog_m.dr(32, 1032'({`JPI_UNLOCK_SIG, 16'h5555}), o, 0);
        check("good signature", prog, 1'b1);
        // disabled port holds the tap in reset, program mode stays
        apb(1'b1, `JPI_OFS_CTRL, 32'h0);
        apb(1'b0, `JPI_OFS_STATUS, 32'h0);
        check("tap held", r, 32'h0000_02f0);
        apb(1'b1, `JPI_OFS_CTRL, 32'h1);
        prog_m.reset_tap();
    endtask

    task automatic t_cmd();
        logic [3:0] c4;
        int base;
        int sb;
        apb(1'b1, `JPI_OFS_CMD_RESULT, 32'h1234);
        prog_m.ir(`JPI_OP_CMD, c4);
        base = execs;
        sb = strobes;
        prog_m.dr(15, 1032'h2a5c, o, 3);
        repeat (3) @(posedge clk_in);
        check("result out", o[14:0], 15'h1234);
        check("cmd word", cmd_word, 15'h2a5c);
        check("strobe count", 32'(strobes - sb), 1);
        check("exec count", 32'(execs - base), 3);
        apb(1'b0, `JPI_OFS_CMD_WORD, 32'h0);
        check("cmd word reg", r, 32'h2a5c);
        base = execs;
        // leaving idle is one more idle tck, then capture disarms
        prog_m.dr(20, 1032'h51c3a, o, 0);
        repeat (3) @(posedge clk_in);
        check("chain length", o[19:15], 5'h1a);
        check("cmd word 2", cmd_word, 15'h28e1);
        check("strobe count 2", 32'(strobes - sb), 2);
        check("exec count 2", 32'(execs - base), 1);
    endtask

    task automatic t_page();
        logic [3:0] c4;
        for (int k = 0; k < 128; k++) begin
            v[8 * k +: 8] = pat(k);
        end
        prog_m.ir(`JPI_OP_PAGE_FILL, c4);
        prog_m.dr(1024, v, o, 0);
        // a partial byte then update must not touch byte 0
        prog_m.dr(4, 1032'h5, o, 0);
        for (int k = 0; k < 128; k += 127) begin
            apb(1'b1, `JPI_OFS_PBUF_ADDR, 32'(k));
            apb(1'b0, `JPI_OFS_PBUF_DATA, 32'h0);
            check("page byte", r, 32'(pat(k)));
        end
        prog_m.ir(`JPI_OP_PAGE_DUMP, c4);
        prog_m.dr(1032, {516{2'b10}}, o, 0);
        check("filler", o[7:0], 8'h00);
        for (int k = 0; k < 128; k++) begin
            check("dump byte", o[8 * k + 8 +: 8], pat(k));
        end
    endtask

    initial begin
        wait (cycles == 40000);
        mismatches = mismatches + 1;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        t_regs();
        t_instr();
        t_core_unlock();
        t_cmd();
        t_page();
        end_sim();
    end
endmodule
